// ### hdl/tsens_spi_port.sv
// Serial slave port and control state of a digital temperature sensor
//
// How it works
// RQ1: After reset the device sits in shutdown, no conversions until written.
// RQ2: A write to the control register changes the operating mode.
// RQ3: A low-supply or power-on reset restores every register default.
// RQ4: Chip select low: clock and data in ignored, data out released.
// RQ5: Chip select rising starts a transaction, falling ends it.
// RQ6: Idle clock level at chip select rise sets polarity for the frame.
// RQ7: Idle high samples on rising edges; idle low samples on falling.
// RQ8: One bit per clock pulse, eight pulses per byte.
// RQ9: First byte is the address; its top bit set means write.
// RQ10: Reads continue with descending addresses while chip select stays high.
// RQ11: Read from the temperature high address gives high, low, control.
// RQ12: Data out stays released through the address byte of a read.
// RQ13: Last read bit level is held until chip select falls.
// RQ14: Writes load the control register; data out stays released.
// RQ15: Reads return temperature and control; data in ignored after address.
// RQ16: All bytes go most significant bit first, address first.
// RQ17: A byte cut short by chip select falling changes nothing.
// RQ18: Control reads at 0x00, written at 0x80; 0x01-0x03 read only.
// RQ19: Bit 0 halts, bit 4 single conversion only while halted, bit 2 one.
// RQ20: Finished single conversion clears bit 4 and stays halted.
// RQ21: The serial port works normally while in shutdown.
`timescale 1ns/1ns
`default_nettype none
module tsens_spi_port
  import tsens_pkg::*;
#(
  parameter logic [7:0] DEV_ID = 8'hC3  // Identification value, arbitrary
)(
  input  wire logic       mclk,         // System clock
  input  wire logic       nrst,         // Reset, active low; synchronous in the mclk domain, asynchronous on the link-side write flops
  input  wire logic       ce,           // Chip select, active high
  input  wire logic       sck,          // Serial clock from the master
  input  wire logic       serial_data_in, // Serial data in
  output logic            serial_data_out, // Serial data out level
  output logic            serial_data_out_oe, // Drive enable for data out
  input  wire logic [9:0] conv_result,  // Converter result word
  input  wire logic       conv_done,    // Converter finished, one pulse
  output logic            conv_run,     // Continuous conversion enabled
  output logic            oneshot_req,  // Single conversion wanted
  output logic            low_power_halt_bit // Shutdown state
);
  link_if lk ();

  // Link domain state
  logic       clock_polarity_setting_r;
  logic [7:0] sh_in_r;
  logic [7:0] sh_nxt;
  logic [2:0] bit_cnt_r;
  logic       addr_done_r;
  logic       dir_write_r;
  logic [7:0] addr_r;
  logic       ctrl_hit_r;
  logic [7:0] wr_data_r;
  logic       wr_tog_r;

  // System domain state
  logic       ce_s;
  logic       tog_s;
  logic       tog_seen_r;
  logic       commit;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [9:0] temp_r;
  logic [9:0] temp_nxt;
  logic [7:0] snap_ctrl_r;
  logic [7:0] snap_lsb_r;
  logic [7:0] snap_msb_r;

  // Polarity follows the idle clock while chip select is low and freezes
  // as it rises; a flop on the chip select edge would switch the mux just
  // after the frame opened and hand the framing a false sample edge
  always_latch
  begin
    if (!ce)
      clock_polarity_setting_r <= sck; // RQ6
  end

  // Sample on the rising clock when idle high, on falling when idle low;
  // parked high outside frames, so opening a frame makes no edge
  assign lk.sclk_s = !ce ? 1'b1 :
                     (clock_polarity_setting_r ? sck : ~sck); // RQ4 RQ7
  assign lk.ce     = ce;

  assign sh_nxt = {sh_in_r[6:0], serial_data_in}; // RQ16

  // Framing: everything here is cleared while chip select is low,
  // so a partial byte is dropped and stray clocks are ignored
  always_ff @(posedge lk.sclk_s or negedge ce)
  begin
    if (!ce)
    begin
      sh_in_r     <= 8'h00; // RQ4 RQ17
      bit_cnt_r   <= FIRST_BIT;
      addr_done_r <= 1'b0; // RQ5
      dir_write_r <= 1'b0;
      addr_r      <= ADDR_RESET;
      ctrl_hit_r  <= 1'b0;
    end
    else
    begin
      sh_in_r   <= sh_nxt;
      bit_cnt_r <= 3'(bit_cnt_r + 3'd1); // RQ8
      if (bit_cnt_r == LAST_BIT && !addr_done_r)
      begin
        addr_done_r <= 1'b1; // RQ9
        dir_write_r <= sh_nxt[DIR_BIT_POS]; // RQ9
        addr_r      <= sh_nxt;
        ctrl_hit_r  <= sh_nxt == ADDR_CTRL_WR; // RQ18
      end
    end
  end

  // Whole written bytes only; the toggle tells the system side
  always_ff @(posedge lk.sclk_s or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_data_r <= 8'h00;
      wr_tog_r  <= 1'b0;
    end
    else if (addr_done_r && dir_write_r && ctrl_hit_r &&
             bit_cnt_r == LAST_BIT)
    begin
      wr_data_r <= sh_nxt; // RQ14 RQ17
      wr_tog_r  <= ~wr_tog_r;
    end
  end

  assign lk.bit_cnt   = bit_cnt_r;
  assign lk.addr_done = addr_done_r;
  assign lk.dir_write = dir_write_r;
  assign lk.addr      = addr_r;

  spi_out_shifter u_tx (
    .lk (lk.tx)
  );

  assign serial_data_out    = lk.dout;
  assign serial_data_out_oe = lk.dout_oe; // RQ4 RQ12

  bit_sync #(.STAGES(SYNC_STAGES)) u_ce_sync (
    .clk  (mclk),
    .nrst (nrst),
    .d    (ce),
    .q    (ce_s)
  );

  bit_sync #(.STAGES(SYNC_STAGES)) u_tog_sync (
    .clk  (mclk),
    .nrst (nrst),
    .d    (wr_tog_r),
    .q    (tog_s)
  );

  // Written data is taken only once the frame is over; the serial clock
  // is then ignored, so the byte cannot move while it is read here
  assign commit = (tog_s != tog_seen_r) && !ce_s;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      tog_seen_r <= 1'b0;
    else if (commit)
      tog_seen_r <= tog_s;
  end

  // A master write beats a conversion finishing in the same cycle
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (commit)
      ctrl_nxt = ctrl_from_write(wr_data_r); // RQ2 RQ19
    else if (conv_done && ctrl_r[HALT_BIT_POS])
      ctrl_nxt[SINGLE_BIT_POS] = 1'b0; // RQ20
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      ctrl_r <= CTRL_RESET; // RQ1 RQ3
    else
      ctrl_r <= ctrl_nxt;
  end

  assign temp_nxt = conv_done ? conv_result : temp_r;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      temp_r <= TEMP_RESET; // RQ3
    else
      temp_r <= temp_nxt;
  end

  // Read images are frozen while a frame is open; chip select setup
  // before the first clock covers the synchroniser delay
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      snap_ctrl_r <= CTRL_RESET; // RQ3
      snap_lsb_r  <= {TEMP_RESET[1:0], 6'h00};
      snap_msb_r  <= TEMP_RESET[9:2];
    end
    else if (!ce_s)
    begin
      snap_ctrl_r <= ctrl_nxt; // RQ15
      snap_lsb_r  <= {temp_nxt[1:0], 6'h00};
      snap_msb_r  <= temp_nxt[9:2];
    end
  end

  assign lk.snap_ctrl = snap_ctrl_r;
  assign lk.snap_lsb  = snap_lsb_r;
  assign lk.snap_msb  = snap_msb_r;
  assign lk.snap_id   = DEV_ID; // RQ18

  // Only conversions stop in shutdown; the port above is never gated
  assign conv_run           = ~ctrl_r[HALT_BIT_POS]; // RQ1 RQ21
  assign oneshot_req        = ctrl_r[HALT_BIT_POS] & ctrl_r[SINGLE_BIT_POS];
  assign low_power_halt_bit = ctrl_r[HALT_BIT_POS];
endmodule
`default_nettype wire

// ### hdl/tsens_pkg.sv
// Shared constants and helpers for the temperature sensor serial port
`default_nettype none
package tsens_pkg;

  // Serial addresses (direction bit included for the write address)
  localparam logic [7:0] ADDR_CTRL_RD  = 8'h00;
  localparam logic [7:0] ADDR_CTRL_WR  = 8'h80;
  localparam logic [7:0] ADDR_TEMP_LSB = 8'h01;
  localparam logic [7:0] ADDR_TEMP_MSB = 8'h02;
  localparam logic [7:0] ADDR_IDENT    = 8'h03;

  // Field positions
  localparam int DIR_BIT_POS    = 7;
  localparam int HALT_BIT_POS   = 0;
  localparam int SINGLE_BIT_POS = 4;
  localparam int FIXED_ONE_POS  = 2;

  // Values after reset
  localparam logic [7:0] CTRL_RESET = 8'h05;
  localparam logic [9:0] TEMP_RESET = 10'h000;
  localparam logic [7:0] ADDR_RESET = 8'h00;

  // Framing
  localparam int          BYTE_BITS   = 8;
  localparam logic [2:0]  LAST_BIT    = 3'h7;
  localparam logic [2:0]  FIRST_BIT   = 3'h0;
  localparam int          SYNC_STAGES = 2;

  // Stored control value from a written byte: unused bits forced,
  // single conversion only kept while the halt bit is also set
  function automatic logic [7:0] ctrl_from_write(input logic [7:0] d);
    logic [7:0] v;
    v = 8'h00;
    v[FIXED_ONE_POS]  = 1'b1;
    v[HALT_BIT_POS]   = d[HALT_BIT_POS];
    v[SINGLE_BIT_POS] = d[SINGLE_BIT_POS] & d[HALT_BIT_POS];
    return v;
  endfunction

endpackage
`default_nettype wire

// ### hdl/link_if.sv
// Signals shared between the receive framing and the output shifter
`timescale 1ns/1ns
`default_nettype none
interface link_if;
  import tsens_pkg::*;
  logic       sclk_s;     // Polarity-corrected link clock
  logic       ce;         // Frame strobe, active high
  logic [2:0] bit_cnt;    // Sample edges seen in current byte
  logic       addr_done;  // Address byte complete
  logic       dir_write;  // Frame is a write
  logic [7:0] addr;       // Captured address
  logic [7:0] snap_ctrl;  // Stable register images for reads
  logic [7:0] snap_lsb;
  logic [7:0] snap_msb;
  logic [7:0] snap_id;
  logic       dout;       // Serial data out level
  logic       dout_oe;    // Serial data out enable

  modport rx (output sclk_s, ce, bit_cnt, addr_done, dir_write, addr,
              output snap_ctrl, snap_lsb, snap_msb, snap_id,
              input dout, dout_oe);
  modport tx (input sclk_s, ce, bit_cnt, addr_done, dir_write, addr,
              input snap_ctrl, snap_lsb, snap_msb, snap_id,
              output dout, dout_oe);
endinterface
`default_nettype wire

// ### hdl/bit_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module bit_sync
  import tsens_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
)(
  input  wire logic clk,   // Destination clock
  input  wire logic nrst,  // Synchronous reset, active low
  input  wire logic d,     // Asynchronous level
  output logic      q      // Synchronised level
);
  logic [STAGES-1:0] pipe_r;

  if (STAGES < 2)
  begin : g_bad_stages
    $error("bit_sync needs at least two stages");
  end

  // First stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!nrst)
      pipe_r <= '0;
    else
      pipe_r <= {pipe_r[STAGES-2:0], d};
  end

  assign q = pipe_r[STAGES-1];
endmodule
`default_nettype wire

// ### hdl/spi_out_shifter.sv
// Read data shifter: drives serial data out on the shift edge
`timescale 1ns/1ns
`default_nettype none
module spi_out_shifter
  import tsens_pkg::*;
(
  link_if.tx lk  // Framing state and register images
);
  logic [7:0] out_sh_r;
  logic [1:0] ptr_r;
  logic       oe_r;
  logic [1:0] ptr_nxt;
  logic       load;

  function automatic logic [7:0] pick(input logic [1:0] p,
                                      input logic [7:0] c,
                                      input logic [7:0] l,
                                      input logic [7:0] m,
                                      input logic [7:0] i);
    case (p)
      ADDR_CTRL_RD[1:0]:  pick = c;
      ADDR_TEMP_LSB[1:0]: pick = l;
      ADDR_TEMP_MSB[1:0]: pick = m;
      default:            pick = i;
    endcase
  endfunction

  // A new byte is due on the first shift edge of every data byte of a read
  assign load    = lk.addr_done && !lk.dir_write && lk.bit_cnt == FIRST_BIT;
  // First byte from the address, then descending addresses
  assign ptr_nxt = oe_r ? 2'(ptr_r - 2'd1) : lk.addr[1:0]; // RQ10 RQ11

  always_ff @(negedge lk.sclk_s or negedge lk.ce)
  begin
    if (!lk.ce)
    begin
      oe_r     <= 1'b0;  // RQ4
      out_sh_r <= 8'h00;
      ptr_r    <= 2'd0;
    end
    else if (load)
    begin
      oe_r     <= 1'b1;  // RQ12
      ptr_r    <= ptr_nxt;
      out_sh_r <= pick(ptr_nxt, lk.snap_ctrl, lk.snap_lsb,
                       lk.snap_msb, lk.snap_id); // RQ15
    end
    else if (oe_r)
      out_sh_r <= {out_sh_r[6:0], out_sh_r[0]}; // RQ16 RQ13
  end

  assign lk.dout    = out_sh_r[7];
  // Release follows the frame strobe without waiting for a clock edge
  assign lk.dout_oe = oe_r & lk.ce; // RQ13 RQ14
endmodule
`default_nettype wire

// ### sim/tsens_spi_port_monitor.sv
// Checker for the sensor serial port
`timescale 1ns/1ns
`default_nettype none
module tsens_spi_port_monitor (
  input wire logic mclk,               // Clock
  input wire logic nrst,               // Reset
  input wire logic ce,                 // Chip select
  input wire logic conv_done,          // Conversion done
  input wire logic serial_data_out_oe, // Out enable
  input wire logic conv_run,           // Running
  input wire logic oneshot_req,        // Single wanted
  input wire logic low_power_halt_bit  // Halted
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_oe_ce_low: assert property (!ce |-> !serial_data_out_oe)
    else $error("out driven, ce low");
  a_run_vs_halt: assert property (conv_run == !low_power_halt_bit)
    else $error("run mismatch");
  a_single_halted: assert property (oneshot_req |-> low_power_halt_bit)
    else $error("single not halted");
  a_reset_dflt: assert property ($rose(nrst) |->
    low_power_halt_bit && !oneshot_req && !conv_run)
    else $error("reset state wrong");
  a_done_clears: assert property (conv_done && oneshot_req |=>
    !oneshot_req && low_power_halt_bit)
    else $error("single not cleared");
  a_ctrl_after_frame: assert property (!$stable(low_power_halt_bit)
    || $rose(oneshot_req) |-> !$past(ce))
    else $error("ctrl changed in frame");
  a_oe_hold_frame: assert property (serial_data_out_oe && ce |=>
    serial_data_out_oe || !ce)
    else $error("out released early");
  a_oe_late_start: assert property ($rose(serial_data_out_oe)
    |-> $past(ce, 5))
    else $error("out driven too soon");
  c_read: cover property ($rose(serial_data_out_oe));
  c_single: cover property (conv_done && oneshot_req);
  c_run: cover property ($rose(conv_run));
endmodule

bind tsens_spi_port tsens_spi_port_monitor i_mon (
  .mclk(mclk), .nrst(nrst), .ce(ce), .conv_done(conv_done),
  .serial_data_out_oe(serial_data_out_oe), .conv_run(conv_run),
  .oneshot_req(oneshot_req), .low_power_halt_bit(low_power_halt_bit));
`default_nettype wire

// ### sim/spi_master_model.sv
// Behavioural serial master facing the sensor port
`timescale 1ns/1ns
`default_nettype none
module spi_master_model (
  output logic      ce,          // Chip select
  output logic      sck,         // Serial clock
  output logic      to_dev,      // Data to device
  input  wire logic from_dev,    // Device data
  input  wire logic from_dev_oe  // Device enable
);
  logic lst = 1'b0;
  logic bad = 1'b0;
  wire  line;
  // Released line shows the inverse of its last level
  assign line = from_dev_oe ? from_dev : ~lst;
  always @(from_dev or from_dev_oe) if (from_dev_oe) lst = from_dev;
  // Chip select falls just after time zero so the frame logic sees a
  // real falling edge to clear on
  initial
  begin
    ce = 1'b1;
    sck = 1'b0;
    to_dev = 1'b0;
    #1 ce = 1'b0;
  end
  task automatic xfer(input logic cp, input logic [7:0] a,
    input logic [7:0] wd, input int nb, output logic [23:0] rd);
    logic [31:0] tx;
    int i;
    tx = {a, wd, wd, wd};
    rd = {3{8'h00}};
    sck = cp;
    to_dev = tx[31];
    #37 ce = 1'b1;
    #420;
    for (i = 0; i < nb; i++)
    begin
      sck = ~cp;
      if (i > 0) to_dev = tx[31 - i];
      #15 sck = cp;
      if (i >= 8) rd = {rd[22:0], line};
      if (from_dev_oe && (i < 8 || a[7])) bad = 1'b1;
      #15;
    end
    #100;
    if (!a[7] && nb > 8 && line !== rd[0]) bad = 1'b1;
    ce = 1'b0;
    #60 if (from_dev_oe !== 1'b0) bad = 1'b1;
    #700;
  endtask
  // Clock and data wiggle with chip select low
  task automatic noise();
    repeat (20)
    begin
      #15 sck = ~sck;
      to_dev = ~to_dev;
    end
  endtask
endmodule
`default_nettype wire

// ### sim/tsens_spi_port_tb.sv
// Self-checking bench for the sensor serial port
`timescale 1ns/1ns
`default_nettype none
module tsens_spi_port_tb;
  import tsens_pkg::*;
  localparam logic [7:0] ID_V = 8'h3A; // Arbitrary identification
  localparam logic [9:0] T_V  = 10'h2A7;
  logic        mclk = 1'b0;
  logic        nrst = 1'b1;
  logic [9:0]  conv_result = 10'h000;
  logic        conv_done = 1'b0;
  logic [23:0] rd;
  wire         ce, sck, to_dev, from_dev, from_dev_oe;
  wire         conv_run, oneshot_req, halt;
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;
  tsens_spi_port #(.DEV_ID(ID_V)) i_dut (
    .mclk(mclk), .nrst(nrst), .ce(ce), .sck(sck),
    .serial_data_in(to_dev), .serial_data_out(from_dev),
    .serial_data_out_oe(from_dev_oe), .conv_result(conv_result),
    .conv_done(conv_done), .conv_run(conv_run),
    .oneshot_req(oneshot_req), .low_power_halt_bit(halt));
  spi_master_model i_mst (.ce(ce), .sck(sck), .to_dev(to_dev),
    .from_dev(from_dev), .from_dev_oe(from_dev_oe));
  initial
  begin
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  function automatic logic [7:0] st();
    return {5'h00, halt, conv_run, oneshot_req};
  endfunction
  task automatic do_reset();
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    #10;
  endtask
  task automatic rdb(input logic cp, input logic [7:0] a,
    input logic [7:0] e);
    i_mst.xfer(cp, a, 8'hFF, 16, rd);
    chk("read", e, rd[7:0]);
    chk("frame", 8'h00, {7'h00, i_mst.bad});
  endtask
  task automatic wrb(input logic cp, input logic [7:0] d, input int nb);
    i_mst.xfer(cp, ADDR_CTRL_WR, d, nb, rd);
    chk("frame", 8'h00, {7'h00, i_mst.bad});
  endtask
  task automatic conv(input logic [9:0] r);
    @(posedge mclk);
    conv_result <= r;
    conv_done <= 1'b1;
    @(posedge mclk);
    conv_done <= 1'b0;
    @(posedge mclk);
    #10;
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    // A scheduled fall gives the link-side write flops a real reset edge
    nrst <= 1'b0;
    do_reset();
    chk("status", 8'h04, st());
    rdb(1'b0, ADDR_CTRL_RD, CTRL_RESET);
    rdb(1'b1, ADDR_IDENT, ID_V);
    i_mst.noise();
    conv(T_V);
    i_mst.xfer(1'b1, ADDR_TEMP_MSB, 8'hFF, 32, rd);
    chk("msb", T_V[9:2], rd[23:16]);
    chk("lsb", {T_V[1:0], 6'h00}, rd[15:8]);
    chk("ctrl", CTRL_RESET, rd[7:0]);
    wrb(1'b0, 8'h11, 16);
    chk("status", 8'h05, st());
    conv(10'h155);
    chk("status", 8'h04, st());
    wrb(1'b1, 8'h10, 16);
    chk("status", 8'h02, st());
    wrb(1'b0, 8'h01, 12);
    chk("status", 8'h02, st());
    rdb(1'b1, ADDR_CTRL_RD, 8'h04);
    wrb(1'b0, 8'hEF, 16);
    rdb(1'b0, ADDR_CTRL_RD, CTRL_RESET);
    wrb(1'b1, 8'h00, 16);
    do_reset();
    chk("status", 8'h04, st());
    rdb(1'b0, ADDR_TEMP_MSB, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
